// ==== hw/uhr_cfg.svh ====
// What this block does
// - Writing one to the reset bit returns pipelines, timers, counters and state machines to initial.
// - A controller reset aborts any USB transaction in progress at once.
// - A controller reset never drives a bus reset on downstream ports.
// - A controller reset leaves the PCI configuration registers untouched.
// - A controller reset returns all operational and port registers to initial values.
// - A controller reset hands all ports back to the companion controllers.
// - Once started, the reset ignores writes of zero and runs to completion.
// - While run/stop is one the schedule executes; writing zero requests a stop.
// - After run/stop clears, outstanding pipeline transactions finish, then the controller halts.
// - The halted bit shows when outstanding work is done and the controller stopped.
// - Status holds only pending interrupts and controller states, no transaction results.
// - Writing one clears a status flag; writing zero leaves it unchanged.
// - Status resets to zero except halted bit 12, which resets to one.
// - Status sits at offset 0x10 of the operational register space.
// - Status bits 15 to 12 are read-only states; bits 5 to 0 are events.
// - Halted reads zero while run/stop is one; set once execution stops.
// - A host system error sets the system error flag and clears run/stop.
`ifndef UHR_CFG_SVH
`define UHR_CFG_SVH

`define UHR_CMD_OFS 8'h00
`define UHR_STS_OFS 8'h10

`define UHR_CMD_RUN_BIT 0
`define UHR_CMD_RST_BIT 1

`define UHR_STS_HALT_BIT 12
`define UHR_STS_RECLAMATION_FLAG_BIT 13
`define UHR_STS_PSS_BIT 14
`define UHR_STS_ASS_BIT 15
`define UHR_STS_FLAG_LSB 0
`define UHR_STS_FLAG_MSB 5
`define UHR_STS_HSE_BIT 4

`define UHR_CMD_RESET 32'h00000000
`define UHR_STS_RESET 32'h00001000

`define UHR_SRST_CYCLES 5'h10

`endif

// ==== hw/uhr_ctrl.sv ====
`timescale 1ns/1ns
`include "uhr_cfg.svh"

module uhr_ctrl (
    input wire logic clk,
    input wire logic reset_n,
    // Operational register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [3:0] reg_be,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    // Event strobes and state levels from the schedule engine
    input wire uhr_pkg::uhr_evt_t evt,
    input wire uhr_pkg::uhr_sched_t sched,
    input wire logic pipe_busy,
    input wire logic port_reset_req,
    // Controls towards pipeline and ports
    output logic schedule_run,
    output logic xact_abort,
    output logic pipeline_init,
    output logic ports_to_companion,
    output logic port_bus_reset,
    output logic soft_reset_busy,
    output logic soft_reset_done
);

    logic run_stop;
    logic srst_active;
    logic srst_done;
    logic srst_start;
    logic controller_halted;
    logic cmd_hit;
    logic sts_hit;
    logic cmd_wr;
    logic sts_wr;
    logic [5:0] flags;
    logic [5:0] flag_set;
    logic [5:0] flag_clr;
    logic [31:0] cmd_view;
    logic [31:0] sts_view;
    logic [31:0] next_rdata;
    uhr_pkg::uhr_sched_t sched_q;
    uhr_pkg::uhr_run_state_t run_state;
    uhr_pkg::uhr_run_state_t next_run_state;

    // Address decode
    always_comb begin
        cmd_hit = 1'b0;
        sts_hit = 1'b0;
        if (reg_addr == `UHR_CMD_OFS) begin
            cmd_hit = 1'b1;
        end else if (reg_addr == `UHR_STS_OFS) begin
            sts_hit = 1'b1;
        end
    end

    // While the reset sequence runs every register write is dropped
    assign cmd_wr = reg_wr && cmd_hit && reg_be[0] && !srst_active;
    assign sts_wr = reg_wr && sts_hit && reg_be[0] && !srst_active;
    assign srst_start = cmd_wr && reg_wdata[`UHR_CMD_RST_BIT];

    uhr_reset_seq u_reset_seq (
        .clk(clk),
        .reset_n(reset_n),
        .start(srst_start),
        .active(srst_active),
        .done(srst_done)
    );

    // Run/stop control bit
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            run_stop <= 1'b0;
        end else if (srst_active) begin
            run_stop <= 1'b0;
        end else if (evt.system_error_flag) begin
            run_stop <= 1'b0;
        end else if (cmd_wr && !srst_start) begin
            run_stop <= reg_wdata[`UHR_CMD_RUN_BIT];
        end
    end

    // Run state machine
    always_comb begin
        next_run_state = run_state;
        case (run_state)
            uhr_pkg::UHR_HALTED: begin
                if (run_stop) begin
                    next_run_state = uhr_pkg::UHR_RUNNING;
                end
            end
            uhr_pkg::UHR_RUNNING: begin
                if (!run_stop) begin
                    next_run_state = uhr_pkg::UHR_STOPPING;
                end
            end
            uhr_pkg::UHR_STOPPING: begin
                // Pipeline drains before the halt is reported
                if (!pipe_busy) begin
                    next_run_state = uhr_pkg::UHR_HALTED;
                end
            end
            default: begin
                next_run_state = uhr_pkg::UHR_HALTED;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            run_state <= uhr_pkg::UHR_HALTED;
        end else if (srst_active) begin
            run_state <= uhr_pkg::UHR_HALTED;
        end else begin
            run_state <= next_run_state;
        end
    end

    // A set run bit forces halted low from the cycle after its write, before run_state leaves halted
    assign controller_halted = (run_state == uhr_pkg::UHR_HALTED) && !run_stop;

    // No new work once stop is requested
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            schedule_run <= 1'b0;
        end else begin
            schedule_run <= run_stop && !srst_active && (next_run_state == uhr_pkg::UHR_RUNNING);
        end
    end

    // Reset side effects on the USB side
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            xact_abort <= 1'b0;
            pipeline_init <= 1'b0;
            ports_to_companion <= 1'b0;
        end else begin
            xact_abort <= srst_start || srst_active;
            pipeline_init <= srst_start || srst_active;
            ports_to_companion <= srst_start || srst_active;
        end
    end

    // A soft reset reinitialises port state without signalling on the wire
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            port_bus_reset <= 1'b0;
        end else begin
            port_bus_reset <= port_reset_req && !srst_start && !srst_active;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            soft_reset_busy <= 1'b0;
            soft_reset_done <= 1'b0;
        end else begin
            soft_reset_busy <= srst_start || srst_active;
            soft_reset_done <= srst_done;
        end
    end

    // Schedule state bits, held at initial value through a soft reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sched_q <= '0;
        end else if (srst_active) begin
            sched_q <= '0;
        end else begin
            sched_q <= sched;
        end
    end

    // Sticky event flags, one-write clears
    assign flag_set = evt;
    assign flag_clr = sts_wr ? reg_wdata[`UHR_STS_FLAG_MSB:`UHR_STS_FLAG_LSB] : 6'h00;

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_flag
            uhr_w1c_flag u_flag (
                .clk(clk),
                .reset_n(reset_n),
                .soft_clear(srst_active),
                .set(flag_set[gi]),
                .clear(flag_clr[gi]),
                .flag(flags[gi])
            );
        end
    endgenerate

    // Register views
    always_comb begin
        cmd_view = `UHR_CMD_RESET;
        cmd_view[`UHR_CMD_RUN_BIT] = run_stop;
        cmd_view[`UHR_CMD_RST_BIT] = srst_active;
    end

    // Only flags and controller states; transaction results never appear
    always_comb begin
        sts_view = 32'h00000000;
        sts_view[`UHR_STS_FLAG_MSB:`UHR_STS_FLAG_LSB] = flags;
        sts_view[`UHR_STS_HALT_BIT] = controller_halted;
        sts_view[`UHR_STS_RECLAMATION_FLAG_BIT] = sched_q.reclamation_flag;
        sts_view[`UHR_STS_PSS_BIT] = sched_q.periodic_sched_state;
        sts_view[`UHR_STS_ASS_BIT] = sched_q.async_sched_state;
    end

    // Read mux; unmapped offsets answer zero
    always_comb begin
        next_rdata = 32'h00000000;
        if (cmd_hit) begin
            next_rdata = cmd_view;
        end else if (sts_hit) begin
            next_rdata = sts_view;
        end
    end

    // Reads take one cycle; data is registered, valid is a pulse
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
        end
    end

    // Configuration space lives elsewhere and never sees srst_active

endmodule : uhr_ctrl

// ==== hw/uhr_pkg.sv ====
package uhr_pkg;

    // Field order matches status bits 5 down to 0
    typedef struct packed {
        logic async_advance_irq;
        logic system_error_flag;
        logic frame_rollover_flag;
        logic port_change_flag;
        logic transfer_error_irq;
        logic transfer_done_irq;
    } uhr_evt_t;

    typedef struct packed {
        logic async_sched_state;
        logic periodic_sched_state;
        logic reclamation_flag;
    } uhr_sched_t;

    typedef enum logic [1:0] {
        UHR_HALTED = 2'h0,
        UHR_RUNNING = 2'h1,
        UHR_STOPPING = 2'h3
    } uhr_run_state_t;

endpackage : uhr_pkg

// ==== hw/uhr_reset_seq.sv ====
`timescale 1ns/1ns
`include "uhr_cfg.svh"

module uhr_reset_seq (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic start,
    output logic active,
    output logic done
);

    logic [4:0] count;

    // No stop input: once started the count always finishes
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            active <= 1'b0;
            count <= 5'h00;
        end else if (!active) begin
            if (start) begin
                active <= 1'b1;
                count <= `UHR_SRST_CYCLES;
            end
        end else if (count == 5'h01) begin
            active <= 1'b0;
            count <= 5'h00;
        end else begin
            count <= count - 5'h01;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            done <= 1'b0;
        end else begin
            done <= active && (count == 5'h01);
        end
    end

endmodule : uhr_reset_seq

// ==== hw/uhr_w1c_flag.sv ====
`timescale 1ns/1ns
`include "uhr_cfg.svh"

module uhr_w1c_flag (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic soft_clear,
    input wire logic set,
    input wire logic clear,
    output logic flag
);

    // Set beats a simultaneous one-write so no event is lost
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            flag <= 1'b0;
        end else if (soft_clear) begin
            flag <= 1'b0;
        end else if (set) begin
            flag <= 1'b1;
        end else if (clear) begin
            flag <= 1'b0;
        end
    end

endmodule : uhr_w1c_flag

// ==== verification/uhr_ctrl_chk.sv ====
`timescale 1ns/1ns
module uhr_ctrl_chk (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire uhr_pkg::uhr_evt_t evt,
    input wire logic port_reset_req,
    input wire logic schedule_run,
    input wire logic xact_abort,
    input wire logic pipeline_init,
    input wire logic ports_to_companion,
    input wire logic port_bus_reset,
    input wire logic soft_reset_busy,
    input wire logic soft_reset_done
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (!reset_n);
    reset_ctl_a: assert property (soft_reset_busy |-> xact_abort && pipeline_init && ports_to_companion)
        else $error("reset controls low while busy");
    reset_len_a: assert property ($rose(soft_reset_busy) |-> ##17 soft_reset_done)
        else $error("reset done late or early");
    done_pulse_a: assert property (soft_reset_done |=> !soft_reset_done && !soft_reset_busy)
        else $error("done not a single pulse");
    no_busrst_a: assert property (soft_reset_busy |-> !port_bus_reset)
        else $error("bus reset during soft reset");
    busrst_fol_a: assert property (!soft_reset_busy ##1 !soft_reset_busy |-> port_bus_reset == $past(port_reset_req))
        else $error("bus reset not following request");
    reset_stop_a: assert property (soft_reset_busy |-> !schedule_run)
        else $error("running during soft reset");
    // Run bit clears on the error edge; the registered run output follows one edge later
    hse_stop_a: assert property (evt.system_error_flag |=> ##1 !schedule_run)
        else $error("system error left run set");
    run_halt_a: assert property (reg_rd && reg_addr == 8'h10 && schedule_run |=> !reg_rdata[12])
        else $error("halted read while running");
    rsvd_zero_a: assert property (reg_rd |=> reg_rvalid && reg_rdata[31:16] == 16'h0000 && reg_rdata[11:6] == 6'h00)
        else $error("reserved bits or read answer wrong");
endmodule : uhr_ctrl_chk

bind uhr_ctrl uhr_ctrl_chk i_uhr_ctrl_chk (.clk(clk), .reset_n(reset_n), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .evt(evt), .port_reset_req(port_reset_req),
    .schedule_run(schedule_run), .xact_abort(xact_abort), .pipeline_init(pipeline_init),
    .ports_to_companion(ports_to_companion), .port_bus_reset(port_bus_reset),
    .soft_reset_busy(soft_reset_busy), .soft_reset_done(soft_reset_done));

// ==== verification/uhr_drv.sv ====
`timescale 1ns/1ns
module uhr_drv (
    input wire logic clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [3:0] reg_be,
    output logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_rvalid
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_be = 4'h0;
        reg_wdata = 32'h00000000;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_be = be;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
        // Stale data must not look like a valid write
        reg_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        d = (reg_rvalid === 1'b1) ? reg_rdata : 32'hXXXXXXXX;
    endtask : rd
endmodule : uhr_drv

// ==== verification/usb_host_run_reset_status_test.sv ====
`timescale 1ns/1ns
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_count++; $display("BAD %s exp %h got %h", n, e, g); end end
module usb_host_run_reset_status_test;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    uhr_pkg::uhr_evt_t evt = '0;
    uhr_pkg::uhr_sched_t sched = '0;
    logic pipe_busy = 1'b0;
    logic port_reset_req = 1'b0;
    logic reg_wr, reg_rd, reg_rvalid, schedule_run, xact_abort, pipeline_init;
    logic ports_to_companion, port_bus_reset, soft_reset_busy, soft_reset_done;
    logic [7:0] reg_addr;
    logic [3:0] reg_be;
    logic [31:0] reg_wdata, reg_rdata, v;
    int err_count = 0;
    int checked = 0;
    // Event pulse, schedule levels, status expected afterwards
    logic [40:0] rows [6] = '{{6'h01, 3'h0, 32'h00001001}, {6'h02, 3'h1, 32'h00003002},
        {6'h04, 3'h2, 32'h00005004}, {6'h08, 3'h4, 32'h00009008}, {6'h10, 3'h7, 32'h0000F010},
        {6'h20, 3'h0, 32'h00001020}};

    uhr_ctrl i_uhr_ctrl (.clk(clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .evt(evt),
        .sched(sched), .pipe_busy(pipe_busy), .port_reset_req(port_reset_req), .schedule_run(schedule_run),
        .xact_abort(xact_abort), .pipeline_init(pipeline_init), .ports_to_companion(ports_to_companion),
        .port_bus_reset(port_bus_reset), .soft_reset_busy(soft_reset_busy), .soft_reset_done(soft_reset_done));
    uhr_drv i_uhr_drv (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_be(reg_be),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    initial begin
        forever #20 clk = ~clk;
    end

    task automatic end_sim;
        $display("Errors %0d in %0d checks", err_count, checked);
        if (err_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    task automatic pulse(input logic [5:0] e);
        @(negedge clk);
        evt = e;
        @(negedge clk);
        evt = '0;
    endtask : pulse

    initial begin
        #40000;
        err_count++;
        end_sim();
    end

    initial begin
        repeat (5) @(negedge clk);
        reset_n = 1'b1;
        i_uhr_drv.rd(8'h10, v);
        `CHK("status rst", 32'h00001000, v)
        i_uhr_drv.rd(8'h00, v);
        `CHK("cmd rst", 32'h00000000, v)
        i_uhr_drv.rd(8'h08, v);
        `CHK("unmapped", 32'h00000000, v)
        foreach (rows[i]) begin
            sched = rows[i][34:32];
            pulse(rows[i][40:35]);
            i_uhr_drv.rd(8'h10, v);
            `CHK("flag set", rows[i][31:0], v)
            i_uhr_drv.wr(8'h10, 32'h00000000, 4'hF);
            i_uhr_drv.rd(8'h10, v);
            `CHK("zero write", rows[i][31:0], v)
            i_uhr_drv.wr(8'h10, 32'hFFFFFFFF, 4'hF);
            i_uhr_drv.rd(8'h10, v);
            `CHK("one write", rows[i][31:0] & 32'h0000F000, v)
        end
        sched = '0;
        i_uhr_drv.wr(8'h00, 32'h00000001, 4'h0);
        @(negedge clk);
        `CHK("lane off", 1'b0, schedule_run)
        // Run is set only once halted reads one
        i_uhr_drv.rd(8'h10, v);
        `CHK("halted", 1'b1, v[12])
        i_uhr_drv.wr(8'h00, 32'h00000001, 4'hF);
        // Schedule enable is registered from the run bit, one edge after the write
        @(negedge clk);
        `CHK("run", 1'b1, schedule_run)
        i_uhr_drv.rd(8'h10, v);
        `CHK("running", 32'h00000000, v)
        pipe_busy = 1'b1;
        i_uhr_drv.wr(8'h00, 32'h00000000, 4'hF);
        @(negedge clk);
        `CHK("stop", 1'b0, schedule_run)
        i_uhr_drv.rd(8'h10, v);
        `CHK("draining", 32'h00000000, v)
        pipe_busy = 1'b0;
        repeat (2) @(negedge clk);
        i_uhr_drv.rd(8'h10, v);
        `CHK("stopped", 32'h00001000, v)
        i_uhr_drv.wr(8'h00, 32'h00000001, 4'hF);
        pulse(6'h10);
        @(negedge clk);
        `CHK("err stop", 1'b0, schedule_run)
        repeat (2) @(negedge clk);
        i_uhr_drv.rd(8'h10, v);
        `CHK("err flag", 32'h00001010, v)
        i_uhr_drv.wr(8'h10, 32'h00000010, 4'hF);
        port_reset_req = 1'b1;
        pulse(6'h08);
        // Controller is halted here, so the reset outcome is defined
        i_uhr_drv.wr(8'h00, 32'h00000002, 4'hF);
        @(negedge clk);
        `CHK("reset ctl", 4'hF, {soft_reset_busy, xact_abort, pipeline_init, ports_to_companion})
        `CHK("bus rst", 1'b0, port_bus_reset)
        i_uhr_drv.wr(8'h00, 32'h00000000, 4'hF);
        i_uhr_drv.rd(8'h00, v);
        `CHK("rst held", 32'h00000002, v)
        for (int i = 0; i < 40 && soft_reset_done !== 1'b1; i++) @(negedge clk);
        `CHK("rst done", 1'b1, soft_reset_done)
        i_uhr_drv.rd(8'h00, v);
        `CHK("rst clear", 32'h00000000, v)
        i_uhr_drv.rd(8'h10, v);
        `CHK("rst status", 32'h00001000, v)
        `CHK("bus rst back", 1'b1, port_bus_reset)
        i_uhr_drv.wr(8'h00, 32'h00000001, 4'hF);
        @(negedge clk);
        `CHK("rerun", 1'b1, schedule_run)
        // Chip reset in mid-run must bring back the halted status word
        reset_n = 1'b0;
        @(negedge clk);
        reset_n = 1'b1;
        i_uhr_drv.rd(8'h10, v);
        `CHK("status hard rst", 32'h00001000, v)
        i_uhr_drv.rd(8'h00, v);
        `CHK("cmd hard rst", 32'h00000000, v)
        end_sim();
    end
endmodule : usb_host_run_reset_status_test
